// ==== inc/cpc_cfg.svh ====
`ifndef CPC_CFG_SVH
`define CPC_CFG_SVH

// ==========================================================
// Time base
// ==========================================================
`define CPC_CLK_KHZ 100000

// ==========================================================
// Detection delays, time then cycle count
// ==========================================================
// overcharge delay
`define CPC_OVC_DLY_MS 120
`define CPC_OVC_DLY_CYC (`CPC_OVC_DLY_MS * `CPC_CLK_KHZ)
`define CPC_UV_DLY_MS 120
`define CPC_UV_DLY_CYC (`CPC_UV_DLY_MS * `CPC_CLK_KHZ)
`define CPC_LOW_DLY_MS 10
`define CPC_LOW_DLY_CYC (`CPC_LOW_DLY_MS * `CPC_CLK_KHZ)
`define CPC_MID_DLY_MS 3
`define CPC_MID_DLY_CYC (`CPC_MID_DLY_MS * `CPC_CLK_KHZ)
`define CPC_SHORT_DLY_US 150
`define CPC_SHORT_DLY_CYC (`CPC_SHORT_DLY_US * `CPC_CLK_KHZ / 1000)
`define CPC_COC_DLY_MS 10
`define CPC_COC_DLY_CYC (`CPC_COC_DLY_MS * `CPC_CLK_KHZ)
`define CPC_CNT_W 24

// ==========================================================
// Synchronised input bit positions
// ==========================================================
`define CPC_IN_W 14
`define CPC_IN_OVC 0
`define CPC_IN_OCR 1
`define CPC_IN_UV 2
`define CPC_IN_UVR 3
`define CPC_IN_LOW 4
`define CPC_IN_MID 5
`define CPC_IN_SHORT 6
`define CPC_IN_COC 7
`define CPC_IN_TEMP 8
`define CPC_IN_TREC 9
`define CPC_IN_CHG 10
`define CPC_IN_CHGREM 11
`define CPC_IN_LOAD 12
`define CPC_IN_LREL 13

// ==========================================================
// Delay timer indices
// ==========================================================
`define CPC_TMR_N 6
`define CPC_T_OVC 0
`define CPC_T_UV 1
`define CPC_T_LOW 2
`define CPC_T_MID 3
`define CPC_T_SHORT 4
`define CPC_T_COC 5

`endif

// ==== inc/cpc_pkg.sv ====
package cpc_pkg;

   // ==========================================================
   // Protection states, one-hot
   // ==========================================================
   typedef enum logic [6:0] {
      CPC_S_NORMAL    = 7'h01,
      CPC_S_OVCHG     = 7'h02,
      CPC_S_UVDSG     = 7'h04,
      CPC_S_OCUR      = 7'h08,
      CPC_S_OTEMP_DSG = 7'h10,
      CPC_S_OTEMP_CHG = 7'h20,
      CPC_S_CHG_OCUR  = 7'h40
   } cpc_state_e;

endpackage

// ==== logic/cpc_controller.sv ====
`timescale 1ns/10ps
`include "cpc_cfg.svh"

// Overview of operation
// - Overvoltage held past its delay switches the pass switch off, blocking charge.
// - Overcharge delay is 120 ms from overvoltage flag rising.
// - Overcharge clears when cell falls below the overcharge release level.
// - Overcharge also clears below trip level with load present; not above it.
// - Undervoltage held past 120 ms blocks discharging.
// - Undervoltage block lifts at once when cell rises above undervoltage_release_level.
// - Three discharge current levels: 10 ms, 3 ms and 150 us delays.
// - Overcurrent block lifts at once when load release asserts.
// - Over temperature switches the pass switch off, charging or discharging.
// - Discharge thermal trip releases on temperature recovered and load released.
// - Charge thermal trip releases on temperature recovered and charger removed.
// - Charge overcurrent held past its delay blocks charging.
// - Charge overcurrent block lifts at once when charger is removed.
// - In undervoltage, charger detected and cell above trip level turns switch on.
// - Entering undervoltage state asserts the power-down output.
module cpc_controller #(
   parameter int unsigned OVC_DLY_CYC = `CPC_OVC_DLY_CYC,
   parameter int unsigned UV_DLY_CYC = `CPC_UV_DLY_CYC,
   parameter int unsigned LOW_DLY_CYC = `CPC_LOW_DLY_CYC,
   parameter int unsigned MID_DLY_CYC = `CPC_MID_DLY_CYC,
   parameter int unsigned SHORT_DLY_CYC = `CPC_SHORT_DLY_CYC,
   parameter int unsigned COC_DLY_CYC = `CPC_COC_DLY_CYC
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Cell voltage comparators
   input wire logic cell_over_trip_i,
   input wire logic cell_below_release_i,
   input wire logic below_undervoltage_trip_level_i,
   input wire logic above_undervoltage_release_level_i,
   // Current comparators
   input wire logic low_current_i,
   input wire logic mid_current_i,
   input wire logic short_current_i,
   input wire logic charge_current_limit_i,
   // Temperature comparators
   input wire logic over_temp_i,
   input wire logic temp_recovered_i,
   // Pack terminal sensing
   input wire logic charger_det_i,
   input wire logic charger_removed_i,
   input wire logic load_present_i,
   input wire logic load_release_i,
   // Switch and mode outputs
   output logic fet_on_o,
   output logic charge_blocked_o,
   output logic discharge_blocked_o,
   output logic power_down_o,
   output logic [6:0] state_o
);

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [`CPC_IN_W-1:0] raw_w;
   logic [`CPC_IN_W-1:0] s1_reg;
   logic [`CPC_IN_W-1:0] s2_reg;
   logic [`CPC_IN_W-1:0] s3_reg;
   logic [`CPC_IN_W-1:0] flt_reg;
   logic [`CPC_IN_W-1:0] flt_next;

   assign raw_w[`CPC_IN_OVC] = cell_over_trip_i;
   assign raw_w[`CPC_IN_OCR] = cell_below_release_i;
   assign raw_w[`CPC_IN_UV] = below_undervoltage_trip_level_i;
   assign raw_w[`CPC_IN_UVR] = above_undervoltage_release_level_i;
   assign raw_w[`CPC_IN_LOW] = low_current_i;
   assign raw_w[`CPC_IN_MID] = mid_current_i;
   assign raw_w[`CPC_IN_SHORT] = short_current_i;
   assign raw_w[`CPC_IN_COC] = charge_current_limit_i;
   assign raw_w[`CPC_IN_TEMP] = over_temp_i;
   assign raw_w[`CPC_IN_TREC] = temp_recovered_i;
   assign raw_w[`CPC_IN_CHG] = charger_det_i;
   assign raw_w[`CPC_IN_CHGREM] = charger_removed_i;
   assign raw_w[`CPC_IN_LOAD] = load_present_i;
   assign raw_w[`CPC_IN_LREL] = load_release_i;

   // Accept a change once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < `CPC_IN_W; gi++) begin : g_sync
         assign flt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : flt_reg[gi];
      end
   endgenerate

   // Synchroniser stages
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         flt_reg <= '0;
      end else begin
         s1_reg <= raw_w;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         flt_reg <= flt_next;
      end
   end

   // ==========================================================
   // Detection delay timers
   // ==========================================================
   localparam int unsigned DLY_CYC [`CPC_TMR_N] = '{
      OVC_DLY_CYC, UV_DLY_CYC, LOW_DLY_CYC, MID_DLY_CYC, SHORT_DLY_CYC, COC_DLY_CYC};

   cpc_pkg::cpc_state_e st_reg;
   cpc_pkg::cpc_state_e st_next;
   logic [`CPC_TMR_N-1:0] tmr_flt_w;
   logic [`CPC_TMR_N-1:0] exp_w;
   logic in_normal_w;

   assign in_normal_w = (st_reg == cpc_pkg::CPC_S_NORMAL);
   assign tmr_flt_w[`CPC_T_OVC] = flt_reg[`CPC_IN_OVC] & in_normal_w;
   assign tmr_flt_w[`CPC_T_UV] = flt_reg[`CPC_IN_UV] & in_normal_w;
   assign tmr_flt_w[`CPC_T_LOW] = flt_reg[`CPC_IN_LOW] & in_normal_w;
   assign tmr_flt_w[`CPC_T_MID] = flt_reg[`CPC_IN_MID] & in_normal_w;
   assign tmr_flt_w[`CPC_T_SHORT] = flt_reg[`CPC_IN_SHORT] & in_normal_w;
   assign tmr_flt_w[`CPC_T_COC] = flt_reg[`CPC_IN_COC] & in_normal_w;

   generate
      for (gi = 0; gi < `CPC_TMR_N; gi++) begin : g_tmr
         cpc_delay_timer #(
            .CYCLES(DLY_CYC[gi])
         ) u_tmr (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .fault_i(tmr_flt_w[gi]),
            .expired_o(exp_w[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Protection state machine
   // ==========================================================
   logic cur_trip_w;
   logic fet_reg;
   logic fet_next;
   logic pd_reg;
   logic pd_next;
   logic cblk_reg;
   logic cblk_next;
   logic dblk_reg;
   logic dblk_next;

   assign cur_trip_w = exp_w[`CPC_T_LOW] | exp_w[`CPC_T_MID] | exp_w[`CPC_T_SHORT];

   // Next state and outputs
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         cpc_pkg::CPC_S_NORMAL: begin
            if (flt_reg[`CPC_IN_TEMP]) begin
               st_next = flt_reg[`CPC_IN_CHG] ? cpc_pkg::CPC_S_OTEMP_CHG
                                               : cpc_pkg::CPC_S_OTEMP_DSG;
            end else if (cur_trip_w) begin
               st_next = cpc_pkg::CPC_S_OCUR;
            end else if (exp_w[`CPC_T_UV]) begin
               st_next = cpc_pkg::CPC_S_UVDSG;
            end else if (exp_w[`CPC_T_COC]) begin
               st_next = cpc_pkg::CPC_S_CHG_OCUR;
            end else if (exp_w[`CPC_T_OVC]) begin
               st_next = cpc_pkg::CPC_S_OVCHG;
            end
         end
         cpc_pkg::CPC_S_OVCHG: begin
            if (flt_reg[`CPC_IN_OCR] ||
                (!flt_reg[`CPC_IN_OVC] && flt_reg[`CPC_IN_LOAD])) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         cpc_pkg::CPC_S_UVDSG: begin
            if (flt_reg[`CPC_IN_UVR] ||
                (flt_reg[`CPC_IN_CHG] && !flt_reg[`CPC_IN_UV])) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         cpc_pkg::CPC_S_OCUR: begin
            if (flt_reg[`CPC_IN_LREL]) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         cpc_pkg::CPC_S_OTEMP_DSG: begin
            if (flt_reg[`CPC_IN_TREC] && flt_reg[`CPC_IN_LREL]) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         cpc_pkg::CPC_S_OTEMP_CHG: begin
            if (flt_reg[`CPC_IN_TREC] && flt_reg[`CPC_IN_CHGREM]) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         cpc_pkg::CPC_S_CHG_OCUR: begin
            if (flt_reg[`CPC_IN_CHGREM]) begin
               st_next = cpc_pkg::CPC_S_NORMAL;
            end
         end
         default: begin
            st_next = cpc_pkg::CPC_S_NORMAL;
         end
      endcase
      fet_next = (st_next == cpc_pkg::CPC_S_NORMAL);
      pd_next = (st_next == cpc_pkg::CPC_S_UVDSG);
      cblk_next = (st_next == cpc_pkg::CPC_S_OVCHG) ||
                  (st_next == cpc_pkg::CPC_S_OTEMP_CHG) ||
                  (st_next == cpc_pkg::CPC_S_CHG_OCUR);
      dblk_next = (st_next == cpc_pkg::CPC_S_UVDSG) ||
                  (st_next == cpc_pkg::CPC_S_OCUR) ||
                  (st_next == cpc_pkg::CPC_S_OTEMP_DSG);
   end

   // State and output registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= cpc_pkg::CPC_S_NORMAL;
         fet_reg <= 1'b1;
         pd_reg <= 1'b0;
         cblk_reg <= 1'b0;
         dblk_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         fet_reg <= fet_next;
         pd_reg <= pd_next;
         cblk_reg <= cblk_next;
         dblk_reg <= dblk_next;
      end
   end

   assign fet_on_o = fet_reg;
   assign power_down_o = pd_reg;
   assign charge_blocked_o = cblk_reg;
   assign discharge_blocked_o = dblk_reg;
   assign state_o = st_reg;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_ovc_entry: assert property ($rose(st_reg == cpc_pkg::CPC_S_OVCHG) |->
      $past(exp_w[`CPC_T_OVC]) && !fet_on_o)
      else $error("overcharge entered without expiry");
   chk_ovc_hold: assert property (st_reg == cpc_pkg::CPC_S_OVCHG &&
      flt_reg[`CPC_IN_OVC] && !flt_reg[`CPC_IN_OCR] |=> st_reg == cpc_pkg::CPC_S_OVCHG)
      else $error("overcharge released above trip level");
   chk_uv_release: assert property (st_reg == cpc_pkg::CPC_S_UVDSG &&
      flt_reg[`CPC_IN_UVR] |=> st_reg == cpc_pkg::CPC_S_NORMAL && fet_on_o)
      else $error("undervoltage not released at once");
   chk_uv_charger: assert property (st_reg == cpc_pkg::CPC_S_UVDSG &&
      flt_reg[`CPC_IN_CHG] && !flt_reg[`CPC_IN_UV] |=> fet_on_o && !power_down_o)
      else $error("charger did not re-enable switch");
   chk_power_down: assert property ($rose(st_reg == cpc_pkg::CPC_S_UVDSG) |->
      power_down_o && discharge_blocked_o)
      else $error("power-down missing in undervoltage");
   chk_cur_trip: assert property (in_normal_w && cur_trip_w &&
      !flt_reg[`CPC_IN_TEMP] |=> st_reg == cpc_pkg::CPC_S_OCUR)
      else $error("current expiry did not trip");
   chk_ocur_release: assert property (st_reg == cpc_pkg::CPC_S_OCUR &&
      flt_reg[`CPC_IN_LREL] |=> in_normal_w)
      else $error("overcurrent not released on load release");
   chk_temp_trip: assert property (in_normal_w && flt_reg[`CPC_IN_TEMP] |=>
      !in_normal_w && !fet_on_o)
      else $error("thermal trip missed");
   chk_temp_dsg: assert property (st_reg == cpc_pkg::CPC_S_OTEMP_DSG &&
      !(flt_reg[`CPC_IN_TREC] && flt_reg[`CPC_IN_LREL]) |=>
      st_reg == cpc_pkg::CPC_S_OTEMP_DSG)
      else $error("discharge thermal trip released early");
   chk_temp_chg: assert property (st_reg == cpc_pkg::CPC_S_OTEMP_CHG &&
      !(flt_reg[`CPC_IN_TREC] && flt_reg[`CPC_IN_CHGREM]) |=>
      st_reg == cpc_pkg::CPC_S_OTEMP_CHG)
      else $error("charge thermal trip released early");
   chk_coc_release: assert property (st_reg == cpc_pkg::CPC_S_CHG_OCUR &&
      flt_reg[`CPC_IN_CHGREM] |=> in_normal_w && !charge_blocked_o)
      else $error("charge overcurrent not released");

endmodule

// ==== logic/cpc_delay_timer.sv ====
`timescale 1ns/10ps
`include "cpc_cfg.svh"

module cpc_delay_timer #(
   parameter int unsigned CYCLES = 1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Fault level in, trip level out
   input wire logic fault_i,
   output logic expired_o
);

   localparam logic [`CPC_CNT_W-1:0] LAST = `CPC_CNT_W'(CYCLES - 1);

   logic [`CPC_CNT_W-1:0] cnt_reg;
   logic [`CPC_CNT_W-1:0] cnt_next;
   logic exp_reg;
   logic exp_next;

   // ==========================================================
   // Count while the fault holds
   // ==========================================================
   // restart on gap
   always_comb begin
      cnt_next = '0;
      exp_next = 1'b0;
      if (fault_i) begin
         cnt_next = (cnt_reg == LAST) ? cnt_reg : cnt_reg + `CPC_CNT_W'(1);
         exp_next = (cnt_reg == LAST);
      end
   end

   // Register the count
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_reg <= '0;
         exp_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         exp_reg <= exp_next;
      end
   end

   assign expired_o = exp_reg;

   // ==========================================================
   // Checks
   // ==========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_timer_restart: assert property (!fault_i |=> cnt_reg == '0 && !expired_o)
      else $error("timer did not restart after fault gap");
   chk_timer_exact: assert property ($rose(expired_o) |-> $past(cnt_reg) == LAST)
      else $error("timer tripped at wrong count");
   chk_timer_cause: assert property (expired_o |-> $past(fault_i))
      else $error("timer tripped without fault");

endmodule

// ==== verification/cell_protection_controller_test.sv ====
`timescale 1ns/10ps
`define CPC_EQ(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end

module cell_protection_controller_test;
   typedef struct {int mv; int ma; logic chg; logic load; int temp; int n;
      cpc_pkg::cpc_state_e st;} cpc_row_s;
   int n_fail = 0;
   int tests_run = 0;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] cell_mv = 16'hE74;
   logic signed [15:0] cur_ma = 16'sh0;
   logic [7:0] temp_c = 8'h1B;
   logic chg = 1'b0;
   logic load = 1'b0;
   logic f_ovt, f_rel, f_uvt, f_uvr, f_low, f_mid, f_sht, f_chl;
   logic f_hot, f_cool, f_cdet, f_crem, f_load, f_lrel;
   logic fet_on_o, charge_blocked_o, discharge_blocked_o, power_down_o;
   logic [6:0] state_o;
   cpc_row_s rows [25];
   cpc_pkg::cpc_state_e prev;
   // Current delays; short level keeps its own 150 us at 100 MHz
   localparam int LOW_CYC = 15016;
   localparam int MID_CYC = 15008;
   localparam int SHORT_CYC = 15000;

   // Clock at 100 MHz
   initial begin
      forever #5 clk_i = ~clk_i;
   end

   cpc_analog_model u_model (.cell_mv_i(cell_mv), .cur_ma_i(cur_ma), .temp_c_i(temp_c),
      .charger_i(chg), .load_i(load), .cell_over_trip_o(f_ovt), .cell_below_release_o(f_rel),
      .below_uv_trip_o(f_uvt), .above_uv_release_o(f_uvr), .low_current_o(f_low),
      .mid_current_o(f_mid), .short_current_o(f_sht), .charge_limit_o(f_chl),
      .over_temp_o(f_hot), .temp_recovered_o(f_cool), .charger_det_o(f_cdet),
      .charger_removed_o(f_crem), .load_present_o(f_load), .load_release_o(f_lrel));

   cpc_controller #(.OVC_DLY_CYC(20), .UV_DLY_CYC(20), .LOW_DLY_CYC(LOW_CYC),
      .MID_DLY_CYC(MID_CYC), .COC_DLY_CYC(10)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cell_over_trip_i(f_ovt), .cell_below_release_i(f_rel),
      .below_undervoltage_trip_level_i(f_uvt), .above_undervoltage_release_level_i(f_uvr),
      .low_current_i(f_low), .mid_current_i(f_mid), .short_current_i(f_sht),
      .charge_current_limit_i(f_chl), .over_temp_i(f_hot), .temp_recovered_i(f_cool),
      .charger_det_i(f_cdet), .charger_removed_i(f_crem), .load_present_i(f_load),
      .load_release_i(f_lrel), .fet_on_o(fet_on_o), .charge_blocked_o(charge_blocked_o),
      .discharge_blocked_o(discharge_blocked_o), .power_down_o(power_down_o),
      .state_o(state_o));

   // Outputs expected for a given state
   task automatic check_outs(input cpc_pkg::cpc_state_e st);
      `CPC_EQ(state_o, st);
      `CPC_EQ(fet_on_o, st == cpc_pkg::CPC_S_NORMAL);
      `CPC_EQ(power_down_o, st == cpc_pkg::CPC_S_UVDSG);
      `CPC_EQ(charge_blocked_o, |(st & 7'h62));
      `CPC_EQ(discharge_blocked_o, |(st & 7'h1C));
   endtask

   // One row: apply quantities, no early trip, then the new state
   task automatic run_row(input cpc_row_s r);
      @(posedge clk_i);
      cell_mv <= r.mv[15:0];
      cur_ma <= r.ma[15:0];
      temp_c <= r.temp[7:0];
      chg <= r.chg;
      load <= r.load;
      repeat (r.n + 4) @(posedge clk_i);
      #1;
      `CPC_EQ(state_o, prev);
      @(posedge clk_i);
      #1;
      check_outs(r.st);
      prev = r.st;
   endtask

   // Verdict and end of run
   task automatic end_of_test();
      $display("counts: run=%0d failed=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Watchdog, the tests need about 45,400 cycles
   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end

   initial begin
      rows = '{'{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{4350, 0, 0, 0, 27, 20, cpc_pkg::CPC_S_OVCHG},
         '{4350, 0, 0, 1, 27, 0, cpc_pkg::CPC_S_OVCHG},
         '{4200, 0, 0, 1, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{4350, 0, 0, 0, 27, 20, cpc_pkg::CPC_S_OVCHG},
         '{4000, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{2600, 0, 0, 0, 27, 20, cpc_pkg::CPC_S_UVDSG},
         '{3100, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{2600, 0, 0, 0, 27, 20, cpc_pkg::CPC_S_UVDSG},
         '{2800, 0, 1, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 4000, 0, 1, 27, LOW_CYC, cpc_pkg::CPC_S_OCUR},
         '{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 8000, 0, 1, 27, MID_CYC, cpc_pkg::CPC_S_OCUR},
         '{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 20000, 0, 1, 27, SHORT_CYC, cpc_pkg::CPC_S_OCUR},
         '{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 0, 0, 1, 150, 0, cpc_pkg::CPC_S_OTEMP_DSG},
         '{3700, 0, 0, 1, 100, 0, cpc_pkg::CPC_S_OTEMP_DSG},
         '{3700, 0, 0, 0, 100, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, 0, 1, 0, 150, 0, cpc_pkg::CPC_S_OTEMP_CHG},
         '{3700, 0, 1, 0, 100, 0, cpc_pkg::CPC_S_OTEMP_CHG},
         '{3700, 0, 0, 0, 100, 0, cpc_pkg::CPC_S_NORMAL},
         '{3700, -5000, 1, 0, 27, 10, cpc_pkg::CPC_S_CHG_OCUR},
         '{3700, 0, 0, 0, 27, 0, cpc_pkg::CPC_S_NORMAL}};
      prev = cpc_pkg::CPC_S_NORMAL;
      // Reset for 6 cycles, then reset values
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      check_outs(cpc_pkg::CPC_S_NORMAL);
      $display("test reset done");
      // Table of trips and releases
      foreach (rows[i]) begin
         run_row(rows[i]);
      end
      $display("test table done");
      // Interrupted overvoltage never trips
      repeat (3) begin
         @(posedge clk_i);
         cell_mv <= 16'h10FE;
         repeat (14) @(posedge clk_i);
         cell_mv <= 16'hE74;
         repeat (6) @(posedge clk_i);
      end
      #1;
      `CPC_EQ(state_o, cpc_pkg::CPC_S_NORMAL);
      $display("test restart done");
      // Reset in mid trip returns to normal
      run_row(cpc_row_s'{2600, 0, 0, 0, 27, 20, cpc_pkg::CPC_S_UVDSG});
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      cell_mv <= 16'hE74;
      repeat (4) @(posedge clk_i);
      #1;
      check_outs(cpc_pkg::CPC_S_NORMAL);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (10) @(posedge clk_i);
      #1;
      check_outs(cpc_pkg::CPC_S_NORMAL);
      $display("test mid reset done");
      end_of_test();
   end
endmodule

// ==== verification/cpc_analog_model.sv ====
`timescale 1ns/10ps

// ==========================================================
// Comparator model of the cell, pack current, die and pack terminal
// ==========================================================
module cpc_analog_model #(
   parameter int OVER_MV = 4300,
   parameter int REL_MV = 4100,
   parameter int UVT_MV = 2750,
   parameter int UVR_MV = 3000,
   parameter int LOW_MA = 3000,
   parameter int MID_MA = 7500,
   parameter int SHORT_MA = 18000,
   parameter int CHG_MA = 4500,
   parameter int HOT_C = 140,
   parameter int COOL_C = 120
) (
   // Physical quantities
   input wire logic [15:0] cell_mv_i,
   input wire logic signed [15:0] cur_ma_i,
   input wire logic [7:0] temp_c_i,
   input wire logic charger_i,
   input wire logic load_i,
   // Comparator flags
   output logic cell_over_trip_o,
   output logic cell_below_release_o,
   output logic below_uv_trip_o,
   output logic above_uv_release_o,
   output logic low_current_o,
   output logic mid_current_o,
   output logic short_current_o,
   output logic charge_limit_o,
   output logic over_temp_o,
   output logic temp_recovered_o,
   output logic charger_det_o,
   output logic charger_removed_o,
   output logic load_present_o,
   output logic load_release_o
);
   // Cell voltage comparators
   assign cell_over_trip_o = int'(cell_mv_i) > OVER_MV;
   assign cell_below_release_o = int'(cell_mv_i) < REL_MV;
   assign below_uv_trip_o = int'(cell_mv_i) < UVT_MV;
   assign above_uv_release_o = int'(cell_mv_i) > UVR_MV;
   // Current levels, positive is discharge
   assign low_current_o = int'(cur_ma_i) > LOW_MA;
   assign mid_current_o = int'(cur_ma_i) > MID_MA;
   assign short_current_o = int'(cur_ma_i) > SHORT_MA;
   assign charge_limit_o = -int'(cur_ma_i) > CHG_MA;
   // Die temperature with hysteresis band
   assign over_temp_o = int'(temp_c_i) > HOT_C;
   assign temp_recovered_o = int'(temp_c_i) < COOL_C;
   // Pack terminal sensing
   assign charger_det_o = charger_i;
   assign charger_removed_o = !charger_i;
   assign load_present_o = load_i;
   assign load_release_o = !load_i;
endmodule
